/* File: src/gei_pkg.sv */
// package for the general-purpose pin and edge interrupt block
// assumes a 32-bit classic wishbone slave with word-aligned byte addresses
package gei_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_READ_LOW     = 8'h00;
    localparam logic [7:0] OFS_OUT_LOW      = 8'h04;
    localparam logic [7:0] OFS_EN_LOW       = 8'h08;
    localparam logic [7:0] OFS_FUNC_LOW     = 8'h0C;
    localparam logic [7:0] OFS_READ_HIGH    = 8'hB0;
    localparam logic [7:0] OFS_OUT_HIGH     = 8'hB4;
    localparam logic [7:0] OFS_EN_HIGH      = 8'hB8;
    localparam logic [7:0] OFS_FUNC_HIGH    = 8'hBC;
    localparam logic [7:0] OFS_IRQ_STAT     = 8'hC0;
    localparam logic [7:0] OFS_IRQ_EN       = 8'hC4;
    // field positions and widths
    localparam int         EDGE_INPUTS      = 7;
    localparam int         RISE_BASE        = 0;
    localparam int         FALL_BASE        = 8;
    localparam int         DISC_BASE        = 16;
    localparam int         DISC_EVENTS      = 7;
    localparam int         CTRL_SOURCES     = 11;
    // reset value and the mask of implemented status bits
    localparam logic [31:0] RST_ZERO        = 32'h0000_0000;
    localparam logic [31:0] STAT_IMPL_MASK  = 32'h007F_7F7F;

    // one pin bank of output control
    typedef struct packed {
        logic [31:0] func;
        logic [31:0] en;
        logic [31:0] val;
    } gei_bank_t;
endpackage : gei_pkg

/* File: src/gei_top.sv */
// general-purpose pins with edge interrupts and output muxing
// assumes pin inputs are asynchronous and primary logic runs on clk_i
//
// How it works
// - only inputs 6..0 of the low pin bank have edge interrupt logic.
// - a rising edge on edge input n sets status bit n.
// - a falling edge on edge input n sets status bit n+8.
// - writing one to a clear bit clears that status bit, zeros leave it alone.
// - a status bit with its enable bit set holds a request pending.
// - rising and falling events of input n both go to controller source 32+n.
// - status bits 16..22 hold disc decoder and encoder events to sources 56..53, bit 23 reserved.
// - 64 output positions each have function, enable and value bits in two banks.
// - after reset all function select bits are zero, so pins take their primary use.
// - with function select zero the primary logic owns enable and value of the pin.
// - with function select one the pin is in general output mode and uses the enable bit.
// - in general output mode enable zero floats the pin and enable one drives it.
// - in general output mode with drive on, the value bit gives the pin level.
// - function select bit 35 moves the audio clock 3 shared pin to general output 35.
// - the read registers always return the pin levels whatever the mode.
//
// Register access over Wishbone and the address map were chosen for this implementation.
`timescale 1ns/10ps
module gei_top #(
    parameter int PINS = 64
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // classic wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // pins
    input  wire logic [PINS-1:0]   pin_in_i,
    output logic      [PINS-1:0]   pin_out_o,
    output logic      [PINS-1:0]   pin_oe_o,
    // primary function logic
    input  wire logic [PINS-1:0]   prim_out_i,
    input  wire logic [PINS-1:0]   prim_oe_i,
    // disc events: new block, illegal sync, missing sync, check error (dec), then enc x3
    input  wire logic [3:0]        disc_dec_event_i,
    input  wire logic [2:0]        disc_enc_event_i,
    // requests to secondary controller, sources 32..38 then 53..56
    output logic [gei_pkg::CTRL_SOURCES-1:0] src_req_o,
    output logic                   irq_o
);
    // pin synchronisers, two stages on every pin
    logic [PINS-1:0]                  pin_s1_q;
    logic [PINS-1:0]                  pin_s2_q;
    // edge detection on the interrupt capable inputs
    logic [gei_pkg::EDGE_INPUTS-1:0]  edge_prev_q;
    logic [gei_pkg::EDGE_INPUTS-1:0]  rise_evt;
    logic [gei_pkg::EDGE_INPUTS-1:0]  fall_evt;
    // interrupt status, enable and the per-cycle set and clear vectors
    logic [31:0]                      edge_irq_status_q;
    logic [31:0]                      edge_irq_enable_q;
    logic [31:0]                      stat_set;
    logic [31:0]                      stat_clr;
    logic [31:0]                      pend;
    // output control registers, low bank positions 31..0, high bank 63..32
    logic [31:0]                      pin_function_select_low_q;
    logic [31:0]                      pin_drive_enable_low_q;
    logic [31:0]                      pin_output_value_low_q;
    logic [31:0]                      pin_function_select_high_q;
    logic [31:0]                      pin_drive_enable_high_q;
    logic [31:0]                      pin_output_value_high_q;
    // banks gathered as structs, then flattened over all 64 positions
    gei_pkg::gei_bank_t               bank_low;
    gei_pkg::gei_bank_t               bank_high;
    logic [63:0]                      func_all;
    logic [63:0]                      en_all;
    logic [63:0]                      val_all;
    // bus side
    logic                             ack_q;
    logic [31:0]                      dat_q;
    logic [31:0]                      rd_mux;
    logic                             req;
    logic                             wr_fire;
    logic [31:0]                      wr_mask;
    // registered outputs and the next value of the controller requests
    logic [PINS-1:0]                  pin_out_q;
    logic [PINS-1:0]                  pin_oe_q;
    logic [gei_pkg::CTRL_SOURCES-1:0] src_req_q;
    logic [gei_pkg::CTRL_SOURCES-1:0] src_req_d;
    logic                             irq_q;
    // position of the pin shared with audio clock 3
    localparam int AUDIO_CLOCK3_SHARED_PIN = 35;

    // a request is live while cyc and stb are both high
    assign req     = wb_cyc_i & wb_stb_i;
    // a write lands at the edge where the master samples ack high
    assign wr_fire = req & wb_we_i & ack_q;
    // byte selects expanded to a bit mask for partial writes
    assign wr_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                      {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // ack comes one cycle after the request is seen and drops the next
    // cycle, so every transfer takes exactly two cycles
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // read data by offset; the clear register reads back as status
    always_comb begin
        rd_mux = gei_pkg::RST_ZERO;
        case (wb_adr_i)
            gei_pkg::OFS_READ_LOW:  rd_mux = pin_s2_q[31:0];
            gei_pkg::OFS_OUT_LOW:   rd_mux = pin_output_value_low_q;
            gei_pkg::OFS_EN_LOW:    rd_mux = pin_drive_enable_low_q;
            gei_pkg::OFS_FUNC_LOW:  rd_mux = pin_function_select_low_q;
            gei_pkg::OFS_READ_HIGH: rd_mux = pin_s2_q[63:32];
            gei_pkg::OFS_OUT_HIGH:  rd_mux = pin_output_value_high_q;
            gei_pkg::OFS_EN_HIGH:   rd_mux = pin_drive_enable_high_q;
            gei_pkg::OFS_FUNC_HIGH: rd_mux = pin_function_select_high_q;
            gei_pkg::OFS_IRQ_STAT:  rd_mux = edge_irq_status_q;
            gei_pkg::OFS_IRQ_EN:    rd_mux = edge_irq_enable_q;
            default:                rd_mux = gei_pkg::RST_ZERO;
        endcase
    end

    // read data captured with ack so it stands while ack is high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= gei_pkg::RST_ZERO;
        end else if (req & ~ack_q & ~wb_we_i) begin
            dat_q <= rd_mux;
        end
    end

    // two flip-flops on every pin before anything reads it; no reset, so
    // the first read after reset already sees the settled pin level
    always_ff @(posedge clk_i) begin
        pin_s1_q <= pin_in_i;
        pin_s2_q <= pin_s1_q;
    end

    // previous sample of the edge inputs, taken from the second stage
    always_ff @(posedge clk_i) begin
        edge_prev_q <= pin_s2_q[gei_pkg::EDGE_INPUTS-1:0];
    end

    // edges by comparing consecutive samples; neither side is reset, so
    // leaving reset cannot fake an edge on a pin that rests high
    assign rise_evt =  pin_s2_q[gei_pkg::EDGE_INPUTS-1:0] & ~edge_prev_q;
    assign fall_evt = ~pin_s2_q[gei_pkg::EDGE_INPUTS-1:0] &  edge_prev_q;

    // events that set status bits this cycle
    always_comb begin
        stat_set = gei_pkg::RST_ZERO;
        stat_set[gei_pkg::RISE_BASE +: gei_pkg::EDGE_INPUTS] = rise_evt;
        stat_set[gei_pkg::FALL_BASE +: gei_pkg::EDGE_INPUTS] = fall_evt;
        stat_set[gei_pkg::DISC_BASE +: 4] = disc_dec_event_i;
        stat_set[gei_pkg::DISC_BASE + 4 +: 3] = disc_enc_event_i;
    end

    // ones written to the clear register clear those bits; it shares its
    // offset with the status register
    assign stat_clr = (wr_fire && wb_adr_i == gei_pkg::OFS_IRQ_STAT) ?
                      (wb_dat_i & wr_mask) : gei_pkg::RST_ZERO;

    // status: a set in the same cycle as a clear wins, so no edge is lost;
    // bit 23 and the unused gaps always read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            edge_irq_status_q <= gei_pkg::RST_ZERO;
        end else begin
            edge_irq_status_q <= ((edge_irq_status_q & ~stat_clr) | stat_set)
                                 & gei_pkg::STAT_IMPL_MASK;
        end
    end

    // interrupt enable, same layout as status
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            edge_irq_enable_q <= gei_pkg::RST_ZERO;
        end else if (wr_fire && wb_adr_i == gei_pkg::OFS_IRQ_EN) begin
            edge_irq_enable_q <= ((edge_irq_enable_q & ~wr_mask) | (wb_dat_i & wr_mask))
                                 & gei_pkg::STAT_IMPL_MASK;
        end
    end

    // low bank function select; zero after reset hands every pin to its
    // primary logic until software claims it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_function_select_low_q <= gei_pkg::RST_ZERO;
        end else if (wr_fire && wb_adr_i == gei_pkg::OFS_FUNC_LOW) begin
            pin_function_select_low_q <= (pin_function_select_low_q & ~wr_mask)
                                         | (wb_dat_i & wr_mask);
        end
    end

    // low bank drive enable, only used in general output mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_drive_enable_low_q <= gei_pkg::RST_ZERO;
        end else if (wr_fire && wb_adr_i == gei_pkg::OFS_EN_LOW) begin
            pin_drive_enable_low_q <= (pin_drive_enable_low_q & ~wr_mask)
                                      | (wb_dat_i & wr_mask);
        end
    end

    // low bank output value, used whenever the pin is in general output mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_output_value_low_q <= gei_pkg::RST_ZERO;
        end else if (wr_fire && wb_adr_i == gei_pkg::OFS_OUT_LOW) begin
            pin_output_value_low_q <= (pin_output_value_low_q & ~wr_mask)
                                      | (wb_dat_i & wr_mask);
        end
    end

    // high bank function select; bit 3 here is position 35, the pin
    // shared with audio clock 3
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_function_select_high_q <= gei_pkg::RST_ZERO;
        end else if (wr_fire && wb_adr_i == gei_pkg::OFS_FUNC_HIGH) begin
            pin_function_select_high_q <= (pin_function_select_high_q & ~wr_mask)
                                          | (wb_dat_i & wr_mask);
        end
    end

    // high bank drive enable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_drive_enable_high_q <= gei_pkg::RST_ZERO;
        end else if (wr_fire && wb_adr_i == gei_pkg::OFS_EN_HIGH) begin
            pin_drive_enable_high_q <= (pin_drive_enable_high_q & ~wr_mask)
                                       | (wb_dat_i & wr_mask);
        end
    end

    // high bank output value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_output_value_high_q <= gei_pkg::RST_ZERO;
        end else if (wr_fire && wb_adr_i == gei_pkg::OFS_OUT_HIGH) begin
            pin_output_value_high_q <= (pin_output_value_high_q & ~wr_mask)
                                       | (wb_dat_i & wr_mask);
        end
    end

    // gather the banks; the high bank holds positions 63..32
    assign bank_low  = '{func: pin_function_select_low_q,
                         en:   pin_drive_enable_low_q,
                         val:  pin_output_value_low_q};
    assign bank_high = '{func: pin_function_select_high_q,
                         en:   pin_drive_enable_high_q,
                         val:  pin_output_value_high_q};
    assign func_all  = {bank_high.func, bank_low.func};
    assign en_all    = {bank_high.en,   bank_low.en};
    assign val_all   = {bank_high.val,  bank_low.val};

    // pin mux: primary logic while select is zero, general output otherwise;
    // registered so the pins only change on the clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_oe_q  <= '0;
            pin_out_q <= '0;
        end else begin
            pin_oe_q  <= (prim_oe_i & ~func_all[PINS-1:0])
                         | (en_all[PINS-1:0] & func_all[PINS-1:0]);
            pin_out_q <= (prim_out_i & ~func_all[PINS-1:0])
                         | (val_all[PINS-1:0] & func_all[PINS-1:0]);
        end
    end

    // a status bit pends while its enable bit is set
    assign pend = edge_irq_status_q & edge_irq_enable_q;

    // controller sources: 32+n takes both edges of input n, 53..56 take the
    // decoder and encoder events, matching events or-ed together
    always_comb begin
        src_req_d = '0;
        for (int n = 0; n < gei_pkg::EDGE_INPUTS; n++) begin
            src_req_d[n] = pend[gei_pkg::RISE_BASE + n]
                           | pend[gei_pkg::FALL_BASE + n];
        end
        src_req_d[gei_pkg::EDGE_INPUTS]     = pend[gei_pkg::DISC_BASE + 3];
        src_req_d[gei_pkg::EDGE_INPUTS + 1] = pend[gei_pkg::DISC_BASE + 2]
                                              | pend[gei_pkg::DISC_BASE + 6];
        src_req_d[gei_pkg::EDGE_INPUTS + 2] = pend[gei_pkg::DISC_BASE + 1]
                                              | pend[gei_pkg::DISC_BASE + 5];
        src_req_d[gei_pkg::EDGE_INPUTS + 3] = pend[gei_pkg::DISC_BASE]
                                              | pend[gei_pkg::DISC_BASE + 4];
    end

    // interrupt and controller requests, registered so outputs are flip-flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src_req_q <= '0;
            irq_q     <= 1'b0;
        end else begin
            src_req_q <= src_req_d;
            irq_q     <= |pend;
        end
    end

    // outputs straight from their flip-flops
    assign wb_ack_o  = ack_q;
    assign wb_dat_o  = dat_q;
    assign pin_out_o = pin_out_q;
    assign pin_oe_o  = pin_oe_q;
    assign src_req_o = src_req_q;
    assign irq_o     = irq_q;

    // checks on what the block drives, one clock after the cause except the reserved bit and reset checks
    rise_sets_stat_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (|rise_evt) |=> ((edge_irq_status_q[gei_pkg::EDGE_INPUTS-1:0] & $past(rise_evt))
                         == $past(rise_evt)))
        else $error("rising edge did not set its status bit");

    fall_sets_stat_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (|fall_evt) |=> ((edge_irq_status_q[gei_pkg::FALL_BASE +: gei_pkg::EDGE_INPUTS]
                          & $past(fall_evt)) == $past(fall_evt)))
        else $error("falling edge did not set its status bit");

    clear_drops_stat_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (|stat_clr) |=> ((edge_irq_status_q & $past(stat_clr) & ~$past(stat_set))
                         == 32'h0000_0000))
        else $error("write of ones did not clear status");

    set_beats_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (|(stat_set & stat_clr)) |=> ((edge_irq_status_q & $past(stat_set & stat_clr))
                                      == $past(stat_set & stat_clr)))
        else $error("clear won over a same cycle event");

    irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> (irq_o == $past(|pend)))
        else $error("interrupt level does not follow pending bits");

    edge_src_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> (src_req_o[0] == $past(pend[gei_pkg::RISE_BASE] | pend[gei_pkg::FALL_BASE])))
        else $error("source 32 request does not follow input 0 events");

    disc_src_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> (src_req_o[gei_pkg::CTRL_SOURCES-1]
                  == $past(pend[gei_pkg::DISC_BASE] | pend[gei_pkg::DISC_BASE + 4])))
        else $error("source 56 request does not follow new block events");

    reserved_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |-> (edge_irq_status_q[23] == 1'b0))
        else $error("reserved status bit set");

    func_reset_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> (func_all == 64'h0))
        else $error("function select not zero after reset");

    primary_owns_pin_a: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> ((pin_out_o & ~$past(func_all[PINS-1:0]))
                  == $past(prim_out_i & ~func_all[PINS-1:0])))
        else $error("primary value not on a primary pin");

    float_or_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> ((pin_oe_o & $past(func_all[PINS-1:0]))
                  == $past(func_all[PINS-1:0] & en_all[PINS-1:0])))
        else $error("general output drive does not follow enable");

    gpo_value_a: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> ((pin_out_o & $past(func_all[PINS-1:0] & en_all[PINS-1:0]))
                  == $past(val_all[PINS-1:0] & func_all[PINS-1:0] & en_all[PINS-1:0])))
        else $error("general output value wrong on a driven pin");

    audio_pin_gpo_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (func_all[AUDIO_CLOCK3_SHARED_PIN] && en_all[AUDIO_CLOCK3_SHARED_PIN])
        |=> (pin_oe_o[AUDIO_CLOCK3_SHARED_PIN]
             && (pin_out_o[AUDIO_CLOCK3_SHARED_PIN] == $past(val_all[AUDIO_CLOCK3_SHARED_PIN]))))
        else $error("shared audio clock pin not in general output mode");
endmodule : gei_top

/* File: testbench/gei_board.sv */
// pads; bench sets ext_i
`timescale 1ns/10ps
module gei_board (
    input  wire logic [63:0] drv_i,
    input  wire logic [63:0] oe_i,
    input  wire logic [63:0] ext_i,
    output logic      [63:0] pad_o);
    assign pad_o = oe_i&drv_i | ~oe_i&ext_i;
endmodule : gei_board

/* File: testbench/test_gei_top.sv */
// bench with pad model
`timescale 1ns/10ps
module test_gei_top;
    logic clk_i=0, rst_i=1, cyc=0, we=0, ack, irq;
    logic [7:0] adr=0;
    logic [31:0] wd=0, rd, eq[$];
    logic [63:0] pad_o, drv_i, oe_i, ext_i=0, pr;
    logic [6:0] dsc=0;
    logic [10:0] src;
    int n_errors=0, n_compared=0, sd=32'hB800;
    always #2.5 clk_i=~clk_i;
    gei_top u_dut (.clk_i,.rst_i,.wb_cyc_i(cyc),.wb_stb_i(cyc),.wb_we_i(we),.wb_adr_i(adr),
    .wb_sel_i(4'hF),.wb_dat_i(wd),.wb_dat_o(rd),.wb_ack_o(ack),.pin_in_i(pad_o),.src_req_o(src),
    .pin_out_o(drv_i),.pin_oe_o(oe_i),.prim_out_i(pr),.prim_oe_i(pr),.disc_dec_event_i(dsc[3:0]),
    .disc_enc_event_i(dsc[6:4]),.irq_o(irq));
    gei_board u_pads (.*);
    task chk(input logic [31:0] g, e); n_compared++; if (g!==e) begin
        n_errors++; $display("CHECK FAILED %0t %h %h", $time, g, e); end endtask : chk
    task bus(input logic w, logic [7:0] a, logic [31:0] d); int i; i=0;
        if (!w) eq.push_back(d); @(posedge clk_i) {cyc,we,adr,wd}<={1'b1,w,a,d};
        do @(posedge clk_i); while (!ack && ++i < 99);
        if (!ack) begin n_errors++; finish_test; end cyc <= 0; endtask : bus
    always @(posedge clk_i) if (cyc & ack & !we) chk(rd, eq.pop_front());
    task finish_test; if (!n_errors && n_compared) $display("*** PASS ***");
        else $display("*** FAIL ***"); $finish; endtask : finish_test
    initial begin pr <= {$random(sd), $random(sd)} & ~64'h7F;
        repeat (16) @(posedge clk_i); rst_i <= 0; repeat (4) @(posedge clk_i);
        bus(0,8'h00,pr[31:0]);
        bus(1,8'h0C,'1); bus(1,8'h08,~32'hFF); bus(1,8'h04,~pr[31:0]); repeat (4) @(posedge clk_i);
        bus(0,8'h00,{~pr[31:8],8'h00});
        bus(1,8'hC4,1); @(posedge clk_i) ext_i[0] <= 1;
        repeat (6) @(posedge clk_i); ext_i[0] <= 0; repeat (8) @(posedge clk_i);
        chk(irq,1); bus(1,8'hC0,1); repeat (2) @(posedge clk_i); chk(irq,0);
        bus(0,8'hC0,32'h100);
        bus(1,8'hC0,32'h100); @(posedge clk_i) dsc <= 7'h10; @(posedge clk_i) dsc <= 0;
        bus(0,8'hC0,32'h0010_0000);
        bus(1,8'hC4,32'h0010_0000); repeat (2) @(posedge clk_i); chk(src,32'h400);
        bus(1,8'hBC,32'h8); bus(1,8'hB8,32'h8); bus(1,8'hB4,{28'h0,~pr[35],3'h0});
        repeat (4) @(posedge clk_i); bus(0,8'hB0,{pr[63:36],~pr[35],pr[34:32]});
        finish_test;
    end
endmodule : test_gei_top
